//--- hdl/mc_status_bank.sv
// One 64-bit machine check status bank with tally and threshold tracking.
`timescale 1ns/1ps
`default_nettype none
module mc_status_bank (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clear,
  input  wire logic [14:0] thresh,
  input  wire logic [15:0] yellow,
  mc_event_if.dst          ev,
  output logic      [63:0] status_r,
  output logic             cei_r
);
  logic [15:0] cnt_nxt;
  logic        corr;
  logic        unc;
  assign corr    = ev.ev_pulse && (ev.ev_kind == 4'h1);
  assign unc     = ev.ev_pulse && (ev.ev_kind != 4'h1);
  assign cnt_nxt = status_r[53:38] + 16'h0001;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= mc_status_pkg::STATUS_RESET; // see RULE4
    end else if (ev.ev_pulse) begin
      if (status_r[mc_status_pkg::POS_VALID]) begin
        status_r[mc_status_pkg::POS_OVER] <= 1'b1; // see RULE1
      end
      status_r[mc_status_pkg::POS_VALID] <= 1'b1; // see RULE4
      if (unc || !status_r[mc_status_pkg::POS_VALID]) begin
        status_r[15:0] <= ev.ev_code; // see RULE2
        status_r[mc_status_pkg::POS_ADDR_VALID] <= ev.ev_addr_ok; // see RULE1
      end
      if (ev.ev_kind == 4'h8) begin
        status_r[mc_status_pkg::POS_EN] <= 1'b1; // see RULE6
      end
      if (corr && status_r[53:38] != 16'hFFFF) begin
        // Tally is saturating; bits 54:53 overlap its top bit.
        status_r[53:38] <= cnt_nxt; // see RULE8
        if (cnt_nxt > yellow) begin
          status_r[54] <= 1'b1; // see RULE3
        end
      end
    end else if (clear) begin
      status_r <= mc_status_pkg::STATUS_RESET;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cei_r <= 1'b0;
    end else begin
      cei_r <= (thresh != 15'h0000) &&
               (status_r[52:38] >= thresh); // see RULE8
    end
  end

  AST_SET_VALID: assert property ( // see RULE4
    @(posedge pclk) disable iff (!presetn)
    ev.ev_pulse |=> status_r[63])
    else $error("valid not set");
  AST_OVER: assert property ( // see RULE1
    @(posedge pclk) disable iff (!presetn)
    (unc && status_r[63] && !ev.ev_addr_ok)
    |=> status_r[62] && !status_r[58])
    else $error("overflow or address valid wrong");
  AST_CODE: assert property ( // see RULE2
    @(posedge pclk) disable iff (!presetn)
    (unc || (corr && !status_r[63]))
    |=> status_r[15:0] == $past(ev.ev_code))
    else $error("code not logged");
  AST_YELLOW: assert property ( // see RULE3
    @(posedge pclk) disable iff (!presetn)
    (status_r[54] && !clear) |=> status_r[54])
    else $error("yellow lost");
  AST_EN: assert property ( // see RULE6
    @(posedge pclk) disable iff (!presetn)
    (ev.ev_pulse && ev.ev_kind == 4'h8) |=> status_r[60])
    else $error("enable not set");
endmodule : mc_status_bank
`default_nettype wire

//--- hdl/mc_status_logger.sv
// Top level: APB slave, event decode and reset tracking for the status bank.
// Notes on behaviour
// RULE1: correctable with address, then uncorrectable without: overflow set, address-valid cleared.
// RULE2: corrected cache data/tag error logs code 000x_0001_xxxx_xx01.
// RULE3: threshold bits 54:53 read 10B past yellow, never back to 00B; here bit 53 is the tally top bit, so they read 11B from a tally of 8000 hex;
// the code returns them to 00B on a clear written to the control register.
// RULE4: valid bit 63 only after real logging; reset clears bank cleanly.
// RULE5: cache slice progress timer expiry logs code 0400 hex.
// RULE6: mid-level cache poisoned fatal error sets the enable flag.
// RULE7: reset with power-ok held high counts as warm reset.
// RULE8: corrected tally in 53:38; interrupt when tally meets threshold; the code compares only bits 52:38 and gives none at threshold 0.
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mc_status_logger (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic        power_ok_pin,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             corrected_error_interrupt
);
  mc_event_if evb ();
  logic [63:0] status;
  logic        cei;
  logic [14:0] thresh_r;
  logic [15:0] yellow_r;
  logic        clear_r;
  logic        pok_s1_r;
  logic        pok_s2_r;
  logic        warm_r;
  logic        ev_pulse_r;
  logic [3:0]  ev_kind_r;
  logic        ev_addr_r;
  logic [15:0] ev_code_r;
  logic        wr;
  logic        rd;
  logic        hit;
  logic [31:0] rdata_nxt;

  // A write takes effect only at the edge where pready is seen high.
  assign wr  = psel && penable && pwrite && pready;
  assign rd  = psel && penable && !pwrite;
  assign hit = (paddr == mc_status_pkg::OFF_STATUS_LO) ||
               (paddr == mc_status_pkg::OFF_STATUS_HI) ||
               (paddr == mc_status_pkg::OFF_CTRL) ||
               (paddr == mc_status_pkg::OFF_THRESH) ||
               (paddr == mc_status_pkg::OFF_EVENT) ||
               (paddr == mc_status_pkg::OFF_RESETINFO);

  assign evb.ev_pulse   = ev_pulse_r;
  assign evb.ev_kind    = ev_kind_r;
  assign evb.ev_addr_ok = ev_addr_r;
  assign evb.ev_code    = ev_code_r;

  mc_status_bank u_bank (
    .pclk     (pclk),
    .presetn  (presetn),
    .clear    (clear_r),
    .thresh   (thresh_r),
    .yellow   (yellow_r),
    .ev       (evb),
    .status_r (status),
    .cei_r    (cei)
  );

  // Power-ok comes from a pin and is synchronised before use.
  // The stages stay out of reset so that they track the pin during reset.
  always_ff @(posedge pclk) begin
    pok_s1_r <= power_ok_pin;
    pok_s2_r <= pok_s1_r;
  end

  // The first clock after release records whether power stayed good.
  logic first_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_r <= 1'b1;
      warm_r  <= 1'b0;
    end else begin
      first_r <= 1'b0;
      if (first_r) begin
        warm_r <= pok_s2_r; // see RULE7
      end
    end
  end

  // Software injected event: writing a nonzero kind to the event register raises one pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_pulse_r <= 1'b0;
      ev_kind_r  <= 4'h0;
      ev_addr_r  <= 1'b0;
      ev_code_r  <= 16'h0000;
    end else begin
      ev_pulse_r <= wr && (paddr == mc_status_pkg::OFF_EVENT) &&
                    (pwdata[3:0] != 4'h0);
      if (wr && paddr == mc_status_pkg::OFF_EVENT) begin
        ev_kind_r <= pwdata[3:0];
        ev_addr_r <= pwdata[4];
        unique case (pwdata[3:0])
          4'h1: ev_code_r <= mc_status_pkg::CODE_CACHE_CORR; // see RULE2
          4'h4: ev_code_r <= mc_status_pkg::CODE_TIMER; // see RULE5
          4'h8: ev_code_r <= mc_status_pkg::CODE_MID_CACHE_FATAL; // see RULE6
          default: ev_code_r <= pwdata[31:16];
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thresh_r <= mc_status_pkg::THRESH_RESET;
      yellow_r <= mc_status_pkg::YELLOW_RESET;
      clear_r  <= 1'b0;
    end else begin
      clear_r <= wr && (paddr == mc_status_pkg::OFF_CTRL) && pwdata[0];
      if (wr && paddr == mc_status_pkg::OFF_THRESH) begin
        thresh_r <= pwdata[14:0]; // see RULE8
        yellow_r <= pwdata[31:16];
      end
    end
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (paddr)
      mc_status_pkg::OFF_STATUS_LO: rdata_nxt = status[31:0];
      mc_status_pkg::OFF_STATUS_HI: rdata_nxt = status[63:32];
      mc_status_pkg::OFF_THRESH:    rdata_nxt = {yellow_r, 1'b0, thresh_r};
      mc_status_pkg::OFF_RESETINFO: rdata_nxt = {31'h0, warm_r};
      default:                      rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Answer in the second access cycle; pready is a registered pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      corrected_error_interrupt <= 1'b0;
    end else begin
      corrected_error_interrupt <= cei; // see RULE8
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !hit;
      if (rd && !pready) begin
        prdata <= rdata_nxt;
      end
    end
  end

  AST_RESET_CLEAN: assert property ( // see RULE4
    @(posedge pclk) disable iff (!presetn)
    first_r |-> status == mc_status_pkg::STATUS_RESET)
    else $error("bank not clean after reset");
  AST_TIMER_CODE: assert property ( // see RULE5
    @(posedge pclk) disable iff (!presetn)
    (ev_pulse_r && ev_kind_r == 4'h4)
    |=> status[15:0] == mc_status_pkg::CODE_TIMER)
    else $error("timer code");
  AST_WARM: assert property ( // see RULE7
    @(posedge pclk) disable iff (!presetn)
    first_r |=> warm_r == $past(pok_s2_r))
    else $error("warm flag");
endmodule : mc_status_logger
`default_nettype wire

//--- shared/mc_event_if.sv
// Interface carrying one decoded error event into the status bank.
`timescale 1ns/1ps
`default_nettype none
interface mc_event_if;
  logic        ev_pulse;
  logic [3:0]  ev_kind;
  logic        ev_addr_ok;
  logic [15:0] ev_code;
  modport src (output ev_pulse, ev_kind, ev_addr_ok, ev_code);
  modport dst (input  ev_pulse, ev_kind, ev_addr_ok, ev_code);
endinterface : mc_event_if
`default_nettype wire

//--- shared/mc_status_pkg.sv
// Package with register map, field positions and codes for the status logger.
package mc_status_pkg;
  localparam logic [11:0] OFF_STATUS_LO = 12'h000;
  localparam logic [11:0] OFF_STATUS_HI = 12'h004;
  localparam logic [11:0] OFF_CTRL      = 12'h008;
  localparam logic [11:0] OFF_THRESH    = 12'h00C;
  localparam logic [11:0] OFF_EVENT     = 12'h010;
  localparam logic [11:0] OFF_RESETINFO = 12'h014;
  localparam int POS_VALID   = 63;
  localparam int POS_OVER    = 62;
  localparam int POS_EN      = 60;
  localparam int POS_ADDR_VALID = 58;
  localparam int POS_TH_LO   = 53;
  localparam int POS_CNT_LO  = 38;
  localparam int CNT_W       = 16;
  localparam int THR_W       = 15;
  localparam logic [1:0]  TH_GREEN   = 2'h0;
  localparam logic [1:0]  TH_YELLOW  = 2'h2;
  localparam logic [15:0] CODE_TIMER = 16'h0400;
  localparam logic [15:0] CODE_CACHE_CORR = 16'h0101;
  localparam logic [15:0] CODE_MID_CACHE_FATAL = 16'h0102;
  localparam logic [14:0] THRESH_RESET    = 15'h0000;
  localparam logic [15:0] YELLOW_RESET    = 16'h0000;
  localparam logic [63:0] STATUS_RESET    = 64'h0;
  // Event kinds carried on the internal event channel.
  typedef enum logic [3:0] {
    EV_CORR   = 4'h1,
    EV_UNCORR = 4'h2,
    EV_TIMER  = 4'h4,
    EV_POISON = 4'h8
  } ev_kind_e;
  localparam logic [31:0] EV_FIELD_MASK = 32'h0000_000F;
endpackage : mc_status_pkg

//--- sim/tb_machine_check_status_logger.sv
// Self-checking bench for the machine check status logger.
`timescale 1ns/1ps
`default_nettype none
module tb_machine_check_status_logger;
  localparam logic [63:0] MASK = 64'hD47F_FFC0_0000_FFFF;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        pok = 1'b1;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cei;
  logic [63:0] exp_st = 64'h0;
  logic [63:0] got;
  logic [31:0] rd;
  logic        err;
  logic [15:0] rc;
  int          tally = 0;
  int          yel = 0;
  int          mismatches = 0;
  int          compares = 0;
  int          cyc = 0;
  int          i;

  always #25 pclk = ~pclk;

  mc_status_logger u_dut (
    .pclk                      (pclk),
    .presetn                   (presetn),
    .psel                      (psel),
    .penable                   (penable),
    .pwrite                    (pwrite),
    .paddr                     (paddr),
    .pwdata                    (pwdata),
    .power_ok_pin              (pok),
    .prdata                    (prdata),
    .pready                    (pready),
    .pslverr                   (pslverr),
    .corrected_error_interrupt (cei)
  );

  task test_done;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      test_done();
    end
  end

  task chk(input logic [63:0] s, input logic [63:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  // One APB transfer; the request is held until pready is sampled high.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd_st;
    apb(1'b0, mc_status_pkg::OFF_STATUS_LO, 32'h0);
    got[31:0] = rd;
    apb(1'b0, mc_status_pkg::OFF_STATUS_HI, 32'h0);
    got[63:32] = rd;
  endtask : rd_st

  task clr;
    apb(1'b1, mc_status_pkg::OFF_CTRL, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    exp_st = 64'h0;
    tally = 0;
  endtask : clr

  // Injects one event, updates the model and compares the logged fields.
  task ev(input logic [3:0] k, input logic a, input logic [15:0] c);
    apb(1'b1, mc_status_pkg::OFF_EVENT, {c, 11'h000, a, k});
    repeat (3) @(posedge pclk);
    exp_st[62] = exp_st[62] | exp_st[63];
    if (k == 4'h1) begin
      if (tally < 65535) tally++;
      exp_st[53:38] = tally[15:0];
      if (tally > yel) exp_st[54] = 1'b1;
      if (!exp_st[63]) begin
        exp_st[15:0] = mc_status_pkg::CODE_CACHE_CORR;
        exp_st[58] = a;
      end
    end else begin
      if (k == 4'h2) exp_st[15:0] = c;
      if (k == 4'h4) exp_st[15:0] = mc_status_pkg::CODE_TIMER;
      if (k == 4'h8) exp_st[15:0] = mc_status_pkg::CODE_MID_CACHE_FATAL;
      exp_st[58] = a;
      if (k == 4'h8) exp_st[60] = 1'b1;
    end
    exp_st[63] = 1'b1;
    rd_st();
    chk(got & MASK, exp_st);
  endtask : ev

  task rst(input logic p);
    @(posedge pclk);
    pok     <= p;
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    exp_st = 64'h0;
    tally = 0;
    yel = 0;
    rd_st();
    chk(got, 64'h0);
    apb(1'b0, mc_status_pkg::OFF_RESETINFO, 32'h0);
    chk({62'h0, err, rd[0]}, {62'h0, 1'b0, p});
  endtask : rst

  initial begin
    void'($urandom(22));
    rst(1'b1);
    apb(1'b1, mc_status_pkg::OFF_THRESH, {16'h0002, 16'h0003});
    yel = 2;
    for (i = 1; i <= 4; i++) begin
      ev(4'h1, 1'b1, 16'h0000);
      chk({63'h0, cei}, {63'h0, (i >= 3)});
      if (i >= 3) chk({62'h0, got[54:53]}, {62'h0, mc_status_pkg::TH_YELLOW});
    end
    clr();
    ev(4'h1, 1'b1, 16'h0000);
    rc = 16'($urandom);
    ev(4'h2, 1'b0, rc);
    chk({62'h0, got[62], got[58]}, 64'h2);
    clr();
    ev(4'h4, 1'b0, 16'h0000);
    clr();
    ev(4'h8, 1'b0, 16'h0000);
    apb(1'b1, mc_status_pkg::OFF_STATUS_HI, 32'h0000_0000);
    rd_st();
    chk(got & MASK, exp_st);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, err, rd}, {31'h0, 1'b1, 32'h0});
    for (i = 0; i < 3; i++) begin
      clr();
      rc = 16'($urandom);
      ev(4'h2, rc[0], rc);
    end
    rst(1'b0);
    test_done();
  end
endmodule : tb_machine_check_status_logger
`default_nettype wire
